// ==== hdl/ttlv_params.svh ====
// Constants for the two-tap line video output formatter.
`ifndef TTLV_PARAMS_SVH
`define TTLV_PARAMS_SVH

// Raw converter sample width and link port width.
`define TTLV_RAW_W 12
`define TTLV_PORT_W 8
`define TTLV_CNT_W 14

// Full-resolution line lengths in pixels.
`define TTLV_LEN_2K 14'h0800
`define TTLV_LEN_4K 14'h1000
`define TTLV_LEN_8K 14'h2000

// Reset values of the link ports and the pair counter.
`define TTLV_PORT_RST 8'h00
`define TTLV_CNT_RST 14'h0000

`endif

// ==== hdl/ttlv_pkg.sv ====
// Types shared by the two-tap line video output formatter.
`default_nettype none
`include "ttlv_params.svh"

package ttlv_pkg;

  // Selectable two-tap pixel depths.
  typedef enum logic [1:0] {
    TTLV_DEPTH_12,
    TTLV_DEPTH_10,
    TTLV_DEPTH_8
  } ttlv_depth_t;

  // Sensor width class of the model.
  typedef enum logic [1:0] {
    TTLV_MODEL_2K,
    TTLV_MODEL_4K,
    TTLV_MODEL_8K
  } ttlv_model_t;

  // Line transfer states.
  typedef enum logic {
    TTLV_IDLE,
    TTLV_SEND
  } ttlv_state_t;

  // Configuration, held steady by the camera control logic.
  typedef struct packed {
    ttlv_depth_t depth;
    ttlv_model_t model;
    logic hbin;
    logic area_of_interest_en;
    logic [`TTLV_CNT_W-1:0] area_of_interest_width;
  } ttlv_cfg_t;

  // One pixel pair as read out of the sensor, raw converter samples.
  typedef struct packed {
    logic [`TTLV_RAW_W-1:0] first_pixel_stream;
    logic [`TTLV_RAW_W-1:0] second_pixel_stream;
  } ttlv_pair_t;

  // Inputs of the serialising link transmitter.
  typedef struct packed {
    logic [`TTLV_PORT_W-1:0] port_a;
    logic [`TTLV_PORT_W-1:0] port_b;
    logic [`TTLV_PORT_W-1:0] port_c;
    logic line_valid;
    logic frame_valid;
    logic data_valid;
    logic spare;
    logic strobe;
  } ttlv_link_t;

endpackage : ttlv_pkg

`default_nettype wire

// ==== hdl/ttlv_out.sv ====
// Two-tap line video output formatter driving the link transmitter inputs.
`default_nettype none
`include "ttlv_params.svh"

// Notes on behaviour
// - Line valid and data valid stay low whenever no valid pixels are sent.
// - After readout completes, both flags rise together on the first transfer cycle.
// - First transfer cycle carries pixel 1 on first stream, pixel 2 on second.
// - Each later cycle advances two pixels, odd on first, even on second.
// - After the last pair both flags fall together.
// - Pixels go out at the selected depth: 12, 10 or 8 bits.
// - Twelve-bit depth maps streams onto ports A, B and C as tabled.
// - Ten-bit depth matches twelve-bit, B2, B3, B6, B7 unused.
// - Eight-bit depth: first stream on A, second on B, C unused.
// - Full-resolution line: 8192, 4096 or 2048 pixels by model.
// - Horizontal binning halves the full-resolution line length.
// - Area of interest, when active, sets the pixels per line.
// - Reduced depths drop two or four converter low bits.
// - Ports and valid flags update on each rising pixel clock edge; the strobe follows the pixel clock.

module ttlv_out (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Configuration from camera control.
  input wire ttlv_pkg::ttlv_cfg_t cfg,
  // Readout handshake and pixel source.
  input wire logic readout_done,
  input wire ttlv_pkg::ttlv_pair_t pair_in,
  output logic pair_take,
  // Pixel clock from the link clock generator.
  input wire logic pix_clk,
  // Link transmitter inputs.
  output ttlv_pkg::ttlv_link_t link,
  output logic busy
);
  import ttlv_pkg::*;

  // ==========================================================================
  // Pixel clock sampling
  // ==========================================================================

  logic pclk_s1_q;
  logic pclk_s2_q;
  logic pclk_s3_q;
  logic pclk_rise;

  // Two flops tame the foreign clock; the third serves edge detection and feeds the strobe.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pclk_s1_q <= 1'b0;
      pclk_s2_q <= 1'b0;
      pclk_s3_q <= 1'b0;
    end else begin
      pclk_s1_q <= pix_clk;
      pclk_s2_q <= pclk_s1_q;
      pclk_s3_q <= pclk_s2_q;
    end
  end

  assign pclk_rise = pclk_s2_q & ~pclk_s3_q;

  // ==========================================================================
  // Line length
  // ==========================================================================

  logic [`TTLV_CNT_W-1:0] full_len;
  logic [`TTLV_CNT_W-1:0] line_len;
  logic [`TTLV_CNT_W:0] len_round;
  logic [`TTLV_CNT_W-1:0] line_pairs;

  always_comb begin
    case (cfg.model)
      TTLV_MODEL_2K: full_len = `TTLV_LEN_2K;
      TTLV_MODEL_4K: full_len = `TTLV_LEN_4K;
      TTLV_MODEL_8K: full_len = `TTLV_LEN_8K;
      default: full_len = `TTLV_LEN_2K;
    endcase
  end

  // Pick the pixel count, then round up to whole pairs. An odd area of
  // interest ends on a pair whose second pixel the receiver should discard.
  always_comb begin
    if (cfg.area_of_interest_en) begin
      line_len = cfg.area_of_interest_width;
    end else if (cfg.hbin) begin
      line_len = full_len >> 1;
    end else begin
      line_len = full_len;
    end
    len_round = {1'b0, line_len} + {{`TTLV_CNT_W{1'b0}}, 1'b1};
    line_pairs = len_round[`TTLV_CNT_W:1];
  end

  // ==========================================================================
  // Line sequencing
  // ==========================================================================

  ttlv_state_t state_q;
  ttlv_state_t state_d;
  logic pending_q;
  logic [`TTLV_CNT_W-1:0] remain_q;
  logic [`TTLV_CNT_W-1:0] remain_d;
  logic start;
  logic load_pair;

  assign start = pclk_rise & (state_q == TTLV_IDLE) & pending_q & (line_pairs != `TTLV_CNT_RST);
  assign load_pair = pclk_rise & (start | ((state_q == TTLV_SEND) & (remain_q != `TTLV_CNT_RST)));

  // A readout arriving in the same cycle a line starts stays pending.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pending_q <= 1'b0;
    end else if (readout_done) begin
      pending_q <= 1'b1;
    end else if (start) begin
      pending_q <= 1'b0;
    end
  end

  // Next state and remaining pair count, changed only on pixel clock edges.
  always_comb begin
    state_d = state_q;
    remain_d = remain_q;
    case (state_q)
      TTLV_IDLE: begin
        if (start) begin
          state_d = TTLV_SEND;
          remain_d = line_pairs - `TTLV_CNT_W'(1);
        end
      end
      TTLV_SEND: begin
        if (pclk_rise) begin
          if (remain_q == `TTLV_CNT_RST) begin
            state_d = TTLV_IDLE;
          end else begin
            remain_d = remain_q - `TTLV_CNT_W'(1);
          end
        end
      end
      default: begin
        state_d = TTLV_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= TTLV_IDLE;
      remain_q <= `TTLV_CNT_RST;
    end else begin
      state_q <= state_d;
      remain_q <= remain_d;
    end
  end

  // ==========================================================================
  // Depth reduction and port mapping
  // ==========================================================================

  logic [`TTLV_PORT_W-1:0] map_a;
  logic [`TTLV_PORT_W-1:0] map_b;
  logic [`TTLV_PORT_W-1:0] map_c;
  logic [`TTLV_RAW_W-1:0] p0;
  logic [`TTLV_RAW_W-1:0] p1;

  assign p0 = pair_in.first_pixel_stream;
  assign p1 = pair_in.second_pixel_stream;

  always_comb begin
    case (cfg.depth)
      TTLV_DEPTH_10: begin
        map_a = p0[9:2];
        map_b = {2'h0, p1[11:10], 2'h0, p0[11:10]};
        map_c = p1[9:2];
      end
      TTLV_DEPTH_8: begin
        map_a = p0[11:4];
        map_b = p1[11:4];
        map_c = `TTLV_PORT_RST;
      end
      default: begin
        map_a = p0[7:0];
        map_b = {p1[11:8], p0[11:8]};
        map_c = p1[7:0];
      end
    endcase
  end

  // ==========================================================================
  // Link output registers
  // ==========================================================================

  logic [`TTLV_PORT_W-1:0] port_a_q;
  logic [`TTLV_PORT_W-1:0] port_b_q;
  logic [`TTLV_PORT_W-1:0] port_c_q;
  logic line_valid_q;
  logic data_valid_q;
  logic frame_valid_q;
  logic spare_q;
  logic strobe_q;
  logic pair_take_q;
  logic busy_q;

  // Data and flags change on the detected pixel clock rise; between edges
  // they hold, giving the receiver one reference cycle of setup before the strobe rise.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_q <= `TTLV_PORT_RST;
      port_b_q <= `TTLV_PORT_RST;
      port_c_q <= `TTLV_PORT_RST;
      line_valid_q <= 1'b0;
      data_valid_q <= 1'b0;
    end else if (load_pair) begin
      port_a_q <= map_a;
      port_b_q <= map_b;
      port_c_q <= map_c;
      line_valid_q <= 1'b1;
      data_valid_q <= 1'b1;
    end else if (pclk_rise) begin
      port_a_q <= `TTLV_PORT_RST;
      port_b_q <= `TTLV_PORT_RST;
      port_c_q <= `TTLV_PORT_RST;
      line_valid_q <= 1'b0;
      data_valid_q <= 1'b0;
    end
  end

  // The strobe lags the data by one reference cycle so that its rising
  // edge never meets changing data at the transmitter.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frame_valid_q <= 1'b0;
      spare_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      frame_valid_q <= 1'b0;
      spare_q <= 1'b0;
      strobe_q <= pclk_s3_q;
    end
  end

  // Source handshake: one pulse per consumed pair; the next pair must be
  // presented before the following pixel clock rise.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pair_take_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      pair_take_q <= load_pair;
      busy_q <= (state_d == TTLV_SEND);
    end
  end

  // Each link field has one owning process; the struct is only assembled here,
  // so no variable is written from two clocked processes.
  assign link = '{port_a: port_a_q, port_b: port_b_q, port_c: port_c_q,
                  line_valid: line_valid_q, frame_valid: frame_valid_q,
                  data_valid: data_valid_q, spare: spare_q, strobe: strobe_q};
  assign pair_take = pair_take_q;
  assign busy = busy_q;

endmodule : ttlv_out

`default_nettype wire

// ==== tb/ttlv_out_assertions.sv ====
// Port checks for the two-tap line video formatter.
`default_nettype none
module ttlv_out_assertions (
  // Clock, reset and inputs.
  input wire logic ref_clk,
  input wire logic resetn,
  input wire ttlv_pkg::ttlv_cfg_t cfg,
  input wire logic readout_done,
  input wire ttlv_pkg::ttlv_pair_t pair_in,
  input wire logic pix_clk,
  // Watched outputs.
  input wire logic pair_take,
  input wire ttlv_pkg::ttlv_link_t link,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import ttlv_pkg::*;
  // ==========================================================
  // Assertions, all in the system clock domain.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  flags_together_a: assert property (link.line_valid == link.data_valid)
    else $error("line and data valid differ");
  idle_quiet_a: assert property (!link.line_valid |-> {link.port_a, link.port_b, link.port_c} == 24'h000000)
    else $error("ports not quiet while idle");
  unused_lines_a: assert property (!link.frame_valid && !link.spare)
    else $error("frame valid or spare active");
  line_start_a: assert property ($rose(link.line_valid) |-> pair_take && busy)
    else $error("line began without a pair load");
  take_spacing_a: assert property (pair_take |=> !pair_take [*6])
    else $error("pair loads closer than a pixel period");
  strobe_after_a: assert property (pair_take |=> $rose(link.strobe))
    else $error("strobe did not follow the data");
  ports_hold_a: assert property (
    link.line_valid && $past(link.line_valid) && !pair_take
    |-> $stable({link.port_a, link.port_b, link.port_c}))
    else $error("ports moved between pixel clocks");
  narrow_c_a: assert property (link.line_valid && cfg.depth == TTLV_DEPTH_8 |-> link.port_c == 8'h00)
    else $error("port C driven at eight bits");
  narrow_b_a: assert property (
    link.line_valid && cfg.depth == TTLV_DEPTH_10
    |-> link.port_b[3:2] == 2'h0 && link.port_b[7:6] == 2'h0)
    else $error("unused B lines driven at ten bits");
  line_end_a: assert property ($fell(link.line_valid) |-> !busy && !pair_take)
    else $error("line ended while still busy");
  // Main scenarios reached.
  cover property ($rose(link.line_valid) && cfg.depth == TTLV_DEPTH_8);
  cover property ($rose(link.line_valid) && cfg.depth == TTLV_DEPTH_10);
  cover property ($fell(link.line_valid));
endmodule : ttlv_out_assertions

bind ttlv_out ttlv_out_assertions i_ttlv_out_assertions (.ref_clk(ref_clk), .resetn(resetn),
  .cfg(cfg), .readout_done(readout_done), .pair_in(pair_in), .pix_clk(pix_clk),
  .pair_take(pair_take), .link(link), .busy(busy));
`default_nettype wire

// ==== tb/ttlv_grabber.sv ====
// Behavioural frame grabber counting the pairs of one line.
`default_nettype none
module ttlv_grabber (
  // Link from the transmitter.
  input wire ttlv_pkg::ttlv_link_t link,
  // Bench control and results.
  input wire logic clr,
  output int pairs,
  output logic [23:0] first_pair,
  output logic [23:0] last_pair
);
  timeunit 1ns;
  timeprecision 1ps;
  import ttlv_pkg::*;
  // ==========================================================
  // Sample on the strobe rise, which lags the data so it has settled.
  // strobe and flags
  always @(posedge link.strobe or posedge clr) begin
    if (clr) begin
      pairs = 0;
    end else if (link.line_valid && link.data_valid) begin
      if (pairs == 0) begin
        first_pair = {link.port_a, link.port_b, link.port_c};
      end
      last_pair = {link.port_a, link.port_b, link.port_c};
      pairs++;
    end
  end
endmodule : ttlv_grabber
`default_nettype wire

// ==== tb/ttlv_out_test.sv ====
// Self-checking bench for the two-tap line video formatter.
`default_nettype none
`define TTLV_CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module ttlv_out_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ttlv_pkg::*;
  // ==========================================================
  // Stimulus and observed signals.
  logic ref_clk = 0;
  logic resetn = 0;
  logic pix_clk = 0;
  logic readout_done = 0;
  logic clr = 0;
  ttlv_cfg_t cfg = '0;
  ttlv_pair_t pair_in = '0;
  logic pair_take;
  logic busy;
  ttlv_link_t link;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h950b;
  int k;
  int pairs;
  logic [11:0] base;
  logic [13:0] w;
  logic [23:0] first_pair;
  logic [23:0] last_pair;
  ttlv_out i_ttlv_out (.ref_clk(ref_clk), .resetn(resetn), .cfg(cfg),
    .readout_done(readout_done), .pair_in(pair_in), .pair_take(pair_take),
    .pix_clk(pix_clk), .link(link), .busy(busy));
  ttlv_grabber i_ttlv_grabber (.link(link), .clr(clr), .pairs(pairs),
    .first_pair(first_pair), .last_pair(last_pair));
  // ==========================================================
  // Clocks; the pixel clock is offset so its edges never meet ours.
  always #4 ref_clk = ~ref_clk;
  initial begin
    #13;
    forever #32 pix_clk = ~pix_clk;
  end
  // Pixel pair idx of the current line.
  function automatic ttlv_pair_t pix_pair(int idx);
    return {12'(base + 2 * idx), 12'(base + 2 * idx + 1)};
  endfunction : pix_pair
  // Expected {A, B, C} for a pair at a depth.
  function automatic logic [23:0] port_map(ttlv_depth_t d, ttlv_pair_t p);
    logic [11:0] x;
    logic [11:0] y;
    x = p.first_pixel_stream;
    y = p.second_pixel_stream;
    case (d)
      TTLV_DEPTH_10: return {x[9:2], 2'h0, y[11:10], 2'h0, x[11:10], y[9:2]};
      TTLV_DEPTH_8: return {x[11:4], y[11:4], 8'h00};
      default: return {x[7:0], y[11:8], x[11:8], y[7:0]};
    endcase
  endfunction : port_map
  // Present the next pair once the current one has been taken.
  always @(negedge ref_clk) begin
    if (pair_take === 1'b1) begin
      k = k + 1;
      pair_in = pix_pair(k);
    end
  end
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // A hang ends the run as a failure.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      close_out;
    end
  end
  // Request one line and check what the grabber saw.
  task automatic run_line(ttlv_depth_t d, ttlv_model_t m, logic hb, logic ae,
                          logic [13:0] aw, int exp);
    int n;
    @(negedge ref_clk);
    cfg = '{d, m, hb, ae, aw};
    base = 12'($random(seed));
    k = 0;
    pair_in = pix_pair(0);
    clr = 1;
    readout_done = 1;
    @(negedge ref_clk);
    clr = 0;
    readout_done = 0;
    n = 0;
    while (busy !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    while (busy === 1'b1 && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (4) @(negedge ref_clk);
    `TTLV_CHK(busy, 1'b0, "line did not end")
    `TTLV_CHK(pairs, exp, "pair count")
    if (exp > 0 && aw[0] == 1'b0) begin
      `TTLV_CHK(first_pair, port_map(d, pix_pair(0)), "first pair")
      `TTLV_CHK(last_pair, port_map(d, pix_pair(exp - 1)), "last pair")
    end
  endtask : run_line
  // ==========================================================
  // Main sequence.
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1;
    // Full and binned lengths across the model classes.
    run_line(TTLV_DEPTH_12, TTLV_MODEL_2K, 1'b0, 1'b0, 14'h0000, 1024);
    run_line(TTLV_DEPTH_8, TTLV_MODEL_8K, 1'b0, 1'b0, 14'h0000, 4096);
    run_line(TTLV_DEPTH_10, TTLV_MODEL_2K, 1'b1, 1'b0, 14'h0000, 512);
    run_line(TTLV_DEPTH_12, TTLV_MODEL_4K, 1'b1, 1'b0, 14'h0000, 1024);
    // Every depth with a random short area of interest.
    for (int i = 0; i < 6; i++) begin
      w = 14'(2 + 2 * ($unsigned($random(seed)) % 8));
      run_line(ttlv_depth_t'(i % 3), TTLV_MODEL_4K, i[0], 1'b1, w, int'(w) / 2);
    end
    // Odd width rounds up; an empty width never starts.
    run_line(TTLV_DEPTH_12, TTLV_MODEL_2K, 1'b0, 1'b1, 14'h0007, 4);
    run_line(TTLV_DEPTH_12, TTLV_MODEL_2K, 1'b0, 1'b1, 14'h0000, 0);
    close_out;
  end
endmodule : ttlv_out_test
`default_nettype wire
